// file: core/sdrd_regs.sv
// response capture, data word buffers and checksum register bank
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module sdrd_regs
  import sdrd_pkg::*;
#(
  parameter int LEN_W = 16
)(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // register port
  input  wire sdrd_bus_s   bus_i,
  output      logic [31:0] rdata_o,
  // protocol engine side
  input  wire sdrd_reply_s reply_i,
  input  wire sdrd_rx_s    rx_i,
  input  wire sdrd_crc_s   crc_i,
  input  wire logic        tx_ready_i,
  output      sdrd_tx_s    tx_o,
  output      logic        rx_take_o,
  output      logic [1:0]  reply_kind_select_o
);

  if (LEN_W != 16) begin : g_bad_len
    $error("sdrd_regs: LEN_W must be 16");
  end

  sdrd_state_s st_q;
  sdrd_state_s st_d;
  logic [31:0] tx_packed;
  logic [31:0] rx_packed;
  logic [2:0]  tx_nbytes;
  logic        wr_tx;
  logic        rd_rx;

  // bytes in the next transmit word; a spent length sends full words
  assign tx_nbytes = (st_q.tx_left == '0 || st_q.tx_left >= 16'h0004)
                     ? BYTES_FULL : st_q.tx_left[2:0];
  assign wr_tx     = bus_i.wr && bus_i.addr == OFS_TX_WORD;
  assign rd_rx     = bus_i.rd && bus_i.addr == OFS_RX_WORD;

  // stuff lanes of a short transmit word are forced to zero
  sdrd_lane_mask u_tx_mask (
    .word_i   (bus_i.wdata),
    .nbytes_i (tx_nbytes),
    .high_i   (1'b1),
    .word_o   (tx_packed)
  );

  // unused upper lanes of a short received word read zero
  sdrd_lane_mask u_rx_mask (
    .word_i   (rx_i.word),
    .nbytes_i (rx_i.nbytes),
    .high_i   (1'b0),
    .word_o   (rx_packed)
  );

  // next state
  always_comb begin
    st_d         = st_q;
    st_d.rdata   = '0;
    st_d.rx_take = 1'b0;

    // reply capture shaped by the selected kind, held otherwise
    if (reply_i.done) begin
      unique case (st_q.kind)
        KIND_BYTE: begin
          st_d.resp_lo = {24'h00_0000, reply_i.reply_bits_low[7:0]};
          st_d.resp_hi = 8'h00;
        end
        KIND_WORD16: begin
          st_d.resp_lo = {16'h0000, reply_i.reply_bits_low[15:0]};
          st_d.resp_hi = 8'h00;
        end
        KIND_BITS40: begin
          st_d.resp_lo = reply_i.reply_bits_low;
          st_d.resp_hi = reply_i.reply_bits_high;
        end
        KIND_NONE: begin
          // no reply expected, keep the previous one
        end
      endcase
    end

    // transmit hand-off completes on ready
    if (st_q.tx.valid && tx_ready_i) begin
      st_d.tx.valid = 1'b0;
    end

    // a write while a word is still pending is dropped: no buffer here
    if (wr_tx && !st_q.tx.valid) begin
      st_d.tx.valid  = 1'b1;
      st_d.tx.word   = tx_packed;
      st_d.tx.nbytes = tx_nbytes;
      st_d.tx_left   = (st_q.tx_left > 16'({13'h0000, tx_nbytes}))
                       ? st_q.tx_left - 16'({13'h0000, tx_nbytes}) : '0;
    end

    // software reads release the receive word
    if (rd_rx) begin
      st_d.rx_full = 1'b0;
      st_d.rx_take = 1'b1;
    end
    // new arrival wins over a same-cycle release
    if (rx_i.valid) begin
      st_d.rx_word = rx_packed;
      st_d.rx_full = 1'b1;
    end

    if (crc_i.done) begin
      st_d.crc = crc_i.value;
    end

    // control writes
    if (bus_i.wr) begin
      if (bus_i.addr == OFS_CONTROL) begin
        st_d.kind = bus_i.wdata[1:0];
      end
      if (bus_i.addr == OFS_TX_LEN) begin
        st_d.tx_left = bus_i.wdata[LEN_W-1:0];
      end
    end

    // read data stand only in the cycle after the strobe
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFS_RESP_LO:  st_d.rdata = st_q.resp_lo;
        OFS_RESP_HI:  st_d.rdata = {24'h00_0000, st_q.resp_hi};
        OFS_RX_WORD:  st_d.rdata = st_q.rx_word;
        OFS_CHECKSUM: st_d.rdata = {16'h0000, st_q.crc};
        OFS_CONTROL:  st_d.rdata = {30'h0000_0000, st_q.kind};
        OFS_STATUS: begin
          st_d.rdata[ST_RX_FULL] = st_q.rx_full;
          st_d.rdata[ST_TX_BUSY] = st_q.tx.valid;
        end
        OFS_TX_LEN:   st_d.rdata = {16'h0000, st_q.tx_left};
        default:      st_d.rdata = '0;   // transmit word and holes read zero
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_q <= STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o             = st_q.rdata;
  assign tx_o                = st_q.tx;
  assign rx_take_o           = st_q.rx_take;
  assign reply_kind_select_o = st_q.kind;

  // checks
  a_resp_one_byte: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    reply_i.done && st_q.kind == KIND_BYTE |=>
      st_q.resp_lo == {24'h00_0000, $past(reply_i.reply_bits_low[7:0])} && st_q.resp_hi == 8'h00)
    else $error("one-byte reply not right-aligned");

  a_resp_word16: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    reply_i.done && st_q.kind == KIND_WORD16 |=>
      st_q.resp_lo[31:16] == 16'h0000 && st_q.resp_hi == 8'h00)
    else $error("16-bit reply upper bits not zero");

  a_resp_bits40: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    reply_i.done && st_q.kind == KIND_BITS40 |=>
      st_q.resp_lo == $past(reply_i.reply_bits_low)
      && st_q.resp_hi == $past(reply_i.reply_bits_high))
    else $error("40-bit reply not captured whole");

  a_resp_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !reply_i.done && !(bus_i.wr && bus_i.addr == OFS_CONTROL) |=>
      $stable(st_q.resp_lo) && $stable(st_q.resp_hi))
    else $error("response changed without a reply");

  a_tx_take_word: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_tx && !st_q.tx.valid |=> tx_o.valid && tx_o.nbytes == $past(tx_nbytes))
    else $error("transmit word not handed on");

  a_tx_stuff_lanes: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tx_o.valid && tx_o.nbytes != BYTES_FULL |->
      (tx_o.word << {tx_o.nbytes, 3'h0}) == 32'h0000_0000)
    else $error("stuff lanes of short transmit word not clear");

  a_rx_upper_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    rx_i.valid && rx_i.nbytes < BYTES_FULL |=>
      (st_q.rx_word >> {$past(rx_i.nbytes), 3'h0}) == 32'h0000_0000 ##1
      (!$past(bus_i.rd) || $past(bus_i.addr) != OFS_RX_WORD
       || rdata_o == $past(st_q.rx_word)))
    else $error("short receive word upper lanes not zero");

  a_rx_read_data: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    rd_rx |=> rdata_o == $past(st_q.rx_word) && rx_take_o)
    else $error("receive read returned wrong data");

  a_crc_capture: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    crc_i.done ##1 (bus_i.rd && bus_i.addr == OFS_CHECKSUM) |=>
      rdata_o == {16'h0000, $past(crc_i.value, 2)})
    else $error("checksum read does not show last value");

  // a stored word must be the masked arrival, and set must beat a same-cycle release
  a_rx_store_word: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    rx_i.valid |=> st_q.rx_full && st_q.rx_word == $past(rx_packed))
    else $error("received word not stored");

  // a pending transmit word may not change until the path has taken it
  a_tx_word_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.word) && $stable(tx_o.nbytes))
    else $error("pending transmit word changed");

  c_reply40: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    reply_i.done && st_q.kind == KIND_BITS40);
  c_reply_none: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    reply_i.done && st_q.kind == KIND_NONE);
  // software writing faster than the path drains: the word is dropped
  c_tx_refused: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_tx && st_q.tx.valid);
  c_tx_short: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    tx_o.valid && tx_o.nbytes == 3'h3 && tx_ready_i);
  c_rx_short_read: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    rx_i.valid && rx_i.nbytes == 3'h1 ##1 rd_rx);

endmodule

// file: core/sdrd_pkg.sv
// constants, types and register map of the response and data register bank
package sdrd_pkg;

  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_RESP_LO  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RESP_HI  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TX_WORD  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RX_WORD  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CHECKSUM = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TX_LEN   = 8'h1C;

  // reply kind codes
  localparam logic [1:0] KIND_NONE   = 2'h0;
  localparam logic [1:0] KIND_BYTE   = 2'h1;
  localparam logic [1:0] KIND_WORD16 = 2'h2;
  localparam logic [1:0] KIND_BITS40 = 2'h3;

  // byte counts of a word
  localparam logic [2:0] BYTES_FULL = 3'h4;
  localparam logic [2:0] BYTES_NONE = 3'h0;

  // status bit positions
  localparam int ST_RX_FULL  = 0;
  localparam int ST_TX_BUSY  = 1;

  // register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } sdrd_bus_s;

  // completed reply from the protocol engine
  typedef struct packed {
    logic        done;
    logic [31:0] reply_bits_low;
    logic [7:0]  reply_bits_high;
  } sdrd_reply_s;

  // received word: valid bytes sit in the low lanes
  typedef struct packed {
    logic        valid;
    logic [2:0]  nbytes;
    logic [31:0] word;
  } sdrd_rx_s;

  // checksum result after a received block
  typedef struct packed {
    logic        done;
    logic [15:0] value;
  } sdrd_crc_s;

  // word handed to the transmit path; valid bytes sit in the high lanes
  typedef struct packed {
    logic        valid;
    logic [2:0]  nbytes;
    logic [31:0] word;
  } sdrd_tx_s;

  // whole state of the register bank
  typedef struct packed {
    logic [31:0] resp_lo;
    logic [7:0]  resp_hi;
    logic [1:0]  kind;
    logic [15:0] tx_left;
    sdrd_tx_s    tx;
    logic [31:0] rx_word;
    logic        rx_full;
    logic        rx_take;
    logic [15:0] crc;
    logic [31:0] rdata;
  } sdrd_state_s;

  localparam sdrd_state_s STATE_RST = '0;

endpackage

// file: core/sdrd_lane_mask.sv
// byte-lane mask for partial final words, high- or low-aligned
`timescale 1ns/1ps
module sdrd_lane_mask
  import sdrd_pkg::*;
(
  // word and its valid byte count
  input  wire logic [31:0] word_i,
  input  wire logic [2:0]  nbytes_i,
  input  wire logic        high_i,
  // masked word
  output      logic [31:0] word_o
);

  // per lane: high alignment keeps the top nbytes lanes, low keeps the bottom
  for (genvar k = 0; k < 4; k++) begin : g_lane
    logic keep;
    assign keep = high_i ? (({1'b0, 3'(k)} + {1'b0, nbytes_i}) >= 4'h4)
                         : ({1'b0, 3'(k)} < {1'b0, nbytes_i});
    assign word_o[8*k +: 8] = keep ? word_i[8*k +: 8] : 8'h00;
  end

endmodule

// file: bench/sdrd_engine_model.sv
// protocol engine stand-in: replies, received words, checksum, transmit sink
`timescale 1ns/1ps
module sdrd_engine_model
  import sdrd_pkg::*;
(
  // clock
  input  wire logic        mclk_i,
  // engine side of the bank
  input  wire sdrd_tx_s    tx_i,
  output      sdrd_reply_s reply_o,
  output      sdrd_rx_s    rx_o,
  output      sdrd_crc_s   crc_o,
  output      logic        tx_ready_o
);
  int       stall  = 0;
  int       wait_n = 0;
  sdrd_tx_s got[$];

  // quiet outputs from time zero
  initial begin
    reply_o    = '0;
    rx_o       = '0;
    crc_o      = '0;
    tx_ready_o = 1'b0;
  end

  // one-cycle pulses; released fields show the inverse, never a stale copy
  task automatic send_reply(input logic [31:0] lo, input logic [7:0] hi);
    @(posedge mclk_i) reply_o <= {1'b1, lo, hi};
    @(posedge mclk_i) reply_o <= {1'b0, ~lo, ~hi};
  endtask

  task automatic send_rx(input logic [2:0] n, input logic [31:0] w);
    @(posedge mclk_i) rx_o <= {1'b1, n, w};
    @(posedge mclk_i) rx_o <= {1'b0, ~n, ~w};
  endtask

  task automatic send_crc(input logic [15:0] v);
    @(posedge mclk_i) crc_o <= {1'b1, v};
    @(posedge mclk_i) crc_o <= {1'b0, ~v};
  endtask

  // sink takes a word after a programmable stall, so busy refusals show
  always @(posedge mclk_i) begin
    if (tx_ready_o && tx_i.valid) begin
      got.push_back(tx_i);
      tx_ready_o <= 1'b0;
      wait_n     <= 0;
    end else if (tx_i.valid) begin
      wait_n     <= wait_n + 1;
      tx_ready_o <= (wait_n >= stall);
    end
  end
endmodule

// file: bench/tb.sv
// self-checking bench of the response and data register bank
`timescale 1ns/1ps
module tb
  import sdrd_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  sdrd_bus_s   bus = '0;
  logic [31:0] rdata;
  sdrd_reply_s reply;
  sdrd_rx_s    rx;
  sdrd_crc_s   crc;
  logic        tx_ready;
  sdrd_tx_s    tx;
  logic        rx_take;
  logic [1:0]  kind;
  int          fail_count = 0;
  int          checked = 0;

  // 50 MHz clock
  always #10 mclk_i = ~mclk_i;

  sdrd_regs #(.LEN_W(16)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .bus_i(bus),
    .rdata_o(rdata), .reply_i(reply), .rx_i(rx), .crc_i(crc), .tx_ready_i(tx_ready),
    .tx_o(tx), .rx_take_o(rx_take), .reply_kind_select_o(kind));

  sdrd_engine_model eng (.mclk_i(mclk_i), .tx_i(tx), .reply_o(reply), .rx_o(rx),
    .crc_o(crc), .tx_ready_o(tx_ready));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // single-cycle strobes, launched just after an edge
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i) bus <= '0;
    // step past the edge so callers see the registered result, not the old one
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge mclk_i) bus <= '0;
    #1 d = rdata;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // reset state, write-only and unmapped places read zero
  task automatic t_reset();
    logic [31:0] v;
    chk("kind", 32'h0000_0000, 32'(kind));
    bus_rd(OFS_RESP_LO, v);
    chk("resp_lo", 32'h0000_0000, v);
    bus_rd(OFS_TX_WORD, v);
    chk("tx_read", 32'h0000_0000, v);
    bus_rd(8'hFC, v);
    chk("unmapped", 32'h0000_0000, v);
    $display("test reset done");
  endtask

  // every reply kind shapes the captured words; kind none keeps them
  task automatic t_reply();
    logic [31:0] v;
    logic [31:0] lo;
    logic [31:0] e;
    for (int k = 1; k < 4; k++) begin
      lo = 32'hA5C3_5A7E + 32'(k);
      bus_wr(OFS_CONTROL, 32'(k));
      chk("kind", 32'(k), 32'(kind));
      eng.send_reply(lo, 8'h3C);
      e = (k == 1) ? {24'h00_0000, lo[7:0]} : (k == 2) ? {16'h0000, lo[15:0]} : lo;
      bus_rd(OFS_RESP_LO, v);
      chk("resp_lo", e, v);
      bus_rd(OFS_RESP_HI, v);
      chk("resp_hi", (k == 3) ? 32'h0000_003C : 32'h0000_0000, v);
    end
    bus_wr(OFS_CONTROL, 32'h0000_0000);
    eng.send_reply(32'h1234_5678, 8'h99);
    bus_rd(OFS_RESP_LO, v);
    chk("resp_held", 32'hA5C3_5A81, v);
    bus_rd(OFS_RESP_HI, v);
    chk("hi_held", 32'h0000_003C, v);
    $display("test reply done");
  endtask

  // short final words come back low-aligned with zero upper lanes
  task automatic t_rx();
    logic [31:0] v;
    logic [31:0] m;
    for (int n = 1; n < 5; n++) begin
      m = (n == 4) ? 32'hFFFF_FFFF : (32'h0000_0001 << (8 * n)) - 32'h0000_0001;
      eng.send_rx(3'(n), 32'hDDCC_BBAA);
      bus_rd(OFS_RX_WORD, v);
      chk("rx_word", 32'hDDCC_BBAA & m, v);
      chk("rx_take", 32'h0000_0001, 32'(rx_take));
    end
    eng.send_crc(16'hBEEF);
    bus_rd(OFS_CHECKSUM, v);
    chk("checksum", 32'h0000_BEEF, v);
    $display("test receive done");
  endtask

  task automatic wait_got(input int n);
    int i;
    for (i = 0; i < 50 && eng.got.size() < n; i++) @(posedge mclk_i);
    if (eng.got.size() < n) begin
      chk("tx_timeout", 32'(n), 32'(eng.got.size()));
      final_report();
    end
  endtask

  // five bytes: full word, refused write while busy, then a one-byte tail
  task automatic t_tx();
    logic [31:0] v;
    eng.stall = 3;
    bus_wr(OFS_TX_LEN, 32'h0000_0005);
    bus_wr(OFS_TX_WORD, 32'h1122_3344);
    bus_wr(OFS_TX_WORD, 32'hAABB_CCDD);
    // first word still pending, so status shows busy and no receive word
    bus_rd(OFS_STATUS, v);
    chk("status_busy", 32'h0000_0002, v);
    wait_got(1);
    bus_wr(OFS_TX_WORD, 32'h99EE_FF77);
    wait_got(2);
    repeat (8) @(posedge mclk_i);
    chk("tx_count", 32'h0000_0002, 32'(eng.got.size()));
    chk("tx_word0", 32'h1122_3344, eng.got[0].word);
    chk("tx_n0", 32'h0000_0004, 32'(eng.got[0].nbytes));
    chk("tx_word1", 32'h9900_0000, eng.got[1].word);
    chk("tx_n1", 32'h0000_0001, 32'(eng.got[1].nbytes));
    $display("test transmit done");
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    t_reset();
    t_reply();
    t_rx();
    t_tx();
    final_report();
  end
endmodule
